/* core/layer_select.sv */
// Per-dot colour layer selection with transparency and invert
`timescale 1ns/1ps
module layer_select import tt_regs_pkg::*; (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Dot inputs
	input wire logic dot_active_in,
	input wire logic invert_in,
	input wire logic [4:0] fg_code_in,
	input wire logic [4:0] bg_code_in,
	input wire logic [4:0] line_code_in,
	// Result
	output logic [4:0] colour_out,
	output logic video_through_out
);
	logic fg_clear;
	logic bg_clear;
	logic [4:0] colour_next;

	// Code zero is see-through, never drawn as black (see RULE1)
	assign fg_clear = (fg_code_in == TRANSPARENT_CODE);
	assign bg_clear = (bg_code_in == TRANSPARENT_CODE);

	always_comb begin
		colour_next = line_code_in;
		if (invert_in) begin
			// see RULE4
			if (dot_active_in) colour_next = bg_clear ? line_code_in : bg_code_in;
			else colour_next = fg_clear ? line_code_in : fg_code_in;
		end else begin
			// see RULE3
			if (dot_active_in) colour_next = fg_clear ? line_code_in : fg_code_in;
			else colour_next = bg_clear ? line_code_in : bg_code_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			colour_out <= TRANSPARENT_CODE;
			video_through_out <= 1'b0;
		end else begin
			colour_out <= colour_next;
			// Transparent result (line layer shown and transparent) lets external video through (see RULE2)
			video_through_out <= (colour_next == TRANSPARENT_CODE);
		end
	end

	a_transp_select: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RULE1
		(fg_code_in == 5'h00 && !invert_in && dot_active_in) |=> colour_out == $past(line_code_in))
		else $error("transparent foreground not replaced by line colour");
	a_normal_active: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RULE3
		(!invert_in && dot_active_in && fg_code_in != 5'h00) |=> colour_out == $past(fg_code_in))
		else $error("active dot lost foreground colour");
	a_invert_active: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RULE4
		(invert_in && dot_active_in && bg_code_in != 5'h00) |=> colour_out == $past(bg_code_in))
		else $error("inverted active dot lost background colour");
	a_video_through: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RULE2
		(!$past(rst_in) && $past(line_code_in) == 5'h00 && $past(fg_code_in) == 5'h00 &&
		$past(bg_code_in) == 5'h00) |-> video_through_out)
		else $error("video pass-through does not follow line transparency");
endmodule

/* core/teletext_display_ctrl_regs.sv */
// Control register bank of the teletext display controller with its timing outputs
`timescale 1ns/1ps
// How it works
// (RULE1) Palette code zero means layer is transparent
// (RULE2) Transparent line layer shows external video
// (RULE3) Normal: active fg, inactive bg, else line
// (RULE4) Invert: active bg, inactive fg, else line
// (RULE5) Registers 0-58 decoded at ascending byte addresses
// (RULE6) Working copies kept in local RAM window
// (RULE7) Sync bits: external, square wave, broad, master
// (RULE8) Sync bit 3 picks 10 or 12 rows
// (RULE9) Sync bit 2 enables interlace phase lock
// (RULE10) Sync bit 1 picks field sync source
// (RULE11) Sync bit 0: 312-line fields or interlace
// (RULE12) Test bit 2 allows palette loads anytime
// (RULE13) Bus request held warning time before takeover
// (RULE14) Font ROM blocked until warning time written
// (RULE15) Command one: video, text, window/box enables
// (RULE16) Command one: palette half, flash enable
// (RULE17) Command two bit 4 steps chapter A
// (RULE18) Command two bit 3 forces default attributes
// (RULE19) Command two: conceal, stack mode, row width
// (RULE20) Display start sets first text scan line
// (RULE21) Page chapter selects one of 64 chapters
// (RULE22) Download tables at chapter pointer times 1024
module teletext_display_ctrl_regs import tt_regs_pkg::*; (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Host memory bus
	input wire logic [19:0] host_addr_in,
	input wire logic host_wr_in,
	input wire logic host_rd_in,
	input wire logic [7:0] host_wdata_in,
	output logic [7:0] host_rdata_out,
	output logic host_hit_out,
	// Timing inputs
	input wire logic hsync_in,
	input wire logic blanking_in,
	input wire logic takeover_req_in,
	input wire logic broad_pulse_in,
	input wire logic rom_req_in,
	input wire logic palette_req_in,
	// Dot path
	input wire logic dot_active_in,
	input wire logic invert_attr_in,
	input wire logic [4:0] fg_code_in,
	input wire logic [4:0] bg_code_in,
	input wire logic [4:0] line_code_in,
	output logic [4:0] dot_colour_out,
	output logic video_through_out,
	// Control outputs
	output logic ext_sync_out,
	output logic square_wave_out,
	output logic broad_pulse_n_out,
	output logic master_out,
	output logic [3:0] cell_rows_out,
	output logic phase_lock_en_out,
	output logic field_src_video_out,
	output logic interlace_out,
	output logic [8:0] field_lines_out,
	output logic palette_xfer_ok_out,
	output logic bus_request_out,
	output logic bus_takeover_out,
	output logic rom_grant_out,
	output logic video_en_out,
	output logic text_en_out,
	output logic window_en_out,
	output logic palette_high_out,
	output logic flash_en_out,
	output logic default_attr_out,
	output logic conceal_en_out,
	output logic explicit_fill_out,
	output logic [6:0] chars_per_row_out,
	output logic [7:0] start_line_out,
	output logic [15:0] page_base_out,
	output logic [16:0] table_a_base_out,
	output logic [16:0] table_b_base_out
);
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WARN = 2'b01,
		BUS_OWN = 2'b10
	} bus_state_t;

	logic [7:0] sync_config_reg;
	logic [7:0] test_config_reg;
	logic [7:0] bus_request_warning_time_reg;
	logic [7:0] display_command_one_reg;
	logic [7:0] display_command_two_reg;
	logic [7:0] vertical_display_start_reg;
	logic [7:0] page_chapter_pointer_reg;
	logic [7:0] download_chapter_a_pointer_reg;
	logic [7:0] download_chapter_b_pointer_reg;
	logic [7:0] copy_ram [0:63];
	logic warn_written_reg;
	bus_state_t bus_state_reg;
	logic [4:0] us_div_reg;
	logic [7:0] warn_left_reg;
	logic [4:0] sq_div_reg;
	logic sq_reg;
	logic hsync_d_reg;
	logic in_main;
	logic in_copy;
	logic [5:0] idx;
	logic [7:0] rdata_next;

	function automatic logic [16:0] chapter_base(input logic [7:0] ptr);
		chapter_base = {1'b0, ptr[5:0], 10'h000} & 17'h0fc00;
	endfunction

	// Primary block and the mirrored working copy (see RULE5)
	assign idx = host_addr_in[5:0];
	assign in_main = (host_addr_in[19:6] == BASE_ADDR[19:6]) && (idx <= LAST_REG_INDEX);
	assign in_copy = (host_addr_in[19:6] == COPY_BASE_ADDR[19:6]);

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			sync_config_reg <= RST_SYNC;
			test_config_reg <= RST_TEST;
			bus_request_warning_time_reg <= RST_WARN;
			display_command_one_reg <= RST_CMD1;
			display_command_two_reg <= RST_CMD2;
			vertical_display_start_reg <= RST_VSTART;
			page_chapter_pointer_reg <= RST_PAGE;
			download_chapter_b_pointer_reg <= RST_CHAP_B;
		end else if (host_wr_in && in_main) begin
			case (idx)
				IDX_SYNC: sync_config_reg <= host_wdata_in;
				IDX_TEST: test_config_reg <= host_wdata_in;
				IDX_WARN: bus_request_warning_time_reg <= host_wdata_in;
				IDX_CMD1: display_command_one_reg <= host_wdata_in;
				IDX_CMD2: display_command_two_reg <= host_wdata_in;
				IDX_VSTART: vertical_display_start_reg <= host_wdata_in;
				IDX_PAGE: page_chapter_pointer_reg <= host_wdata_in;
				IDX_CHAP_B: download_chapter_b_pointer_reg <= host_wdata_in;
				default: ;
			endcase
		end
	end

	// Chapter A has a second writer: the line-rate stepper (see RULE17)
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			download_chapter_a_pointer_reg <= RST_CHAP_A;
			hsync_d_reg <= 1'b0;
		end else begin
			hsync_d_reg <= hsync_in;
			if (host_wr_in && in_main && idx == IDX_CHAP_A)
				download_chapter_a_pointer_reg <= host_wdata_in;
			else if (display_command_two_reg[CMD2_AINC_BIT] && hsync_in && !hsync_d_reg)
				download_chapter_a_pointer_reg <= download_chapter_a_pointer_reg + 8'h01;
		end
	end

	// Copy window tracks every primary write; direct writes there are honoured too (see RULE6)
	always_ff @(posedge ref_clk_in) begin
		if (host_wr_in && (in_main || in_copy))
			copy_ram[idx] <= host_wdata_in;
	end

	// Font ROM stays locked until software programs the warning time (see RULE14)
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) warn_written_reg <= 1'b0;
		else if (host_wr_in && in_main && idx == IDX_WARN) warn_written_reg <= 1'b1;
	end

	always_comb begin
		rdata_next = 8'h00;
		if (in_copy) rdata_next = copy_ram[idx];
		else if (in_main) begin
			case (idx)
				IDX_SYNC: rdata_next = sync_config_reg;
				IDX_TEST: rdata_next = test_config_reg;
				IDX_WARN: rdata_next = bus_request_warning_time_reg;
				IDX_CMD1: rdata_next = display_command_one_reg;
				IDX_CMD2: rdata_next = display_command_two_reg;
				IDX_VSTART: rdata_next = vertical_display_start_reg;
				IDX_PAGE: rdata_next = page_chapter_pointer_reg;
				IDX_CHAP_A: rdata_next = download_chapter_a_pointer_reg;
				IDX_CHAP_B: rdata_next = download_chapter_b_pointer_reg;
				default: rdata_next = copy_ram[idx];
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			host_rdata_out <= 8'h00;
			host_hit_out <= 1'b0;
		end else begin
			host_rdata_out <= host_rd_in ? rdata_next : 8'h00;
			host_hit_out <= (host_rd_in || host_wr_in) && (in_main || in_copy);
		end
	end

	// Bus request runs the programmed microseconds before takeover (see RULE13)
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			bus_state_reg <= BUS_IDLE;
			us_div_reg <= 5'd0;
			warn_left_reg <= 8'h00;
		end else begin
			case (bus_state_reg)
				BUS_IDLE: begin
					if (takeover_req_in) begin
						bus_state_reg <= (bus_request_warning_time_reg == 8'h00) ? BUS_OWN : BUS_WARN;
						us_div_reg <= 5'd0;
						warn_left_reg <= bus_request_warning_time_reg;
					end
				end
				BUS_WARN: begin
					if (us_div_reg == US_CYCLES - 5'd1) begin
						us_div_reg <= 5'd0;
						warn_left_reg <= warn_left_reg - 8'h01;
						if (warn_left_reg == 8'h01) bus_state_reg <= BUS_OWN;
					end else us_div_reg <= us_div_reg + 5'd1;
				end
				BUS_OWN: if (!takeover_req_in) bus_state_reg <= BUS_IDLE;
				default: bus_state_reg <= BUS_IDLE;
			endcase
		end
	end

	// Square wave only counts while enabled (see RULE7)
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			sq_div_reg <= 5'd0;
			sq_reg <= 1'b0;
		end else if (!sync_config_reg[SYNC_SQ_BIT]) begin
			sq_div_reg <= 5'd0;
			sq_reg <= 1'b0;
		end else if (sq_div_reg == SQ_HALF_CYCLES - 5'd1) begin
			sq_div_reg <= 5'd0;
			sq_reg <= ~sq_reg;
		end else sq_div_reg <= sq_div_reg + 5'd1;
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			ext_sync_out <= 1'b0;
			square_wave_out <= 1'b0;
			broad_pulse_n_out <= 1'b1;
			master_out <= 1'b0;
			cell_rows_out <= ROWS_SHORT;
			phase_lock_en_out <= 1'b0;
			field_src_video_out <= 1'b0;
			interlace_out <= 1'b0;
			field_lines_out <= EVEN_FIELD_LINES;
		end else begin
			ext_sync_out <= sync_config_reg[SYNC_EXT_BIT]; // see RULE7
			square_wave_out <= sq_reg;
			broad_pulse_n_out <= !(sync_config_reg[SYNC_BROAD_BIT] && broad_pulse_in);
			master_out <= sync_config_reg[SYNC_MASTER_BIT];
			cell_rows_out <= sync_config_reg[SYNC_ROWS_BIT] ? ROWS_TALL : ROWS_SHORT; // see RULE8
			phase_lock_en_out <= sync_config_reg[SYNC_PLL_BIT]; // see RULE9
			field_src_video_out <= sync_config_reg[SYNC_FSRC_BIT]; // see RULE10
			interlace_out <= sync_config_reg[SYNC_ILACE_BIT]; // see RULE11
			field_lines_out <= EVEN_FIELD_LINES;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			palette_xfer_ok_out <= 1'b0;
			bus_request_out <= 1'b0;
			bus_takeover_out <= 1'b0;
			rom_grant_out <= 1'b0;
		end else begin
			// see RULE12
			palette_xfer_ok_out <= palette_req_in &&
				(test_config_reg[TEST_ANYTIME_BIT] || blanking_in);
			bus_request_out <= (bus_state_reg != BUS_IDLE); // see RULE13
			bus_takeover_out <= (bus_state_reg == BUS_OWN);
			rom_grant_out <= rom_req_in && warn_written_reg; // see RULE14
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			video_en_out <= 1'b0;
			text_en_out <= 1'b0;
			window_en_out <= 1'b0;
			palette_high_out <= 1'b0;
			flash_en_out <= 1'b0;
			default_attr_out <= 1'b0;
			conceal_en_out <= 1'b0;
			explicit_fill_out <= 1'b0;
			chars_per_row_out <= CHARS_NARROW;
			start_line_out <= 8'h00;
			page_base_out <= 16'h0000;
			table_a_base_out <= 17'h00000;
			table_b_base_out <= 17'h00000;
		end else begin
			video_en_out <= display_command_one_reg[CMD1_VIDEO_BIT]; // see RULE15
			text_en_out <= display_command_one_reg[CMD1_TEXT_BIT];
			window_en_out <= display_command_one_reg[CMD1_WINDOW_BIT];
			palette_high_out <= display_command_one_reg[CMD1_PAL_BIT]; // see RULE16
			flash_en_out <= display_command_one_reg[CMD1_FLASH_BIT];
			default_attr_out <= display_command_two_reg[CMD2_DEFATTR_BIT]; // see RULE18
			conceal_en_out <= !display_command_two_reg[CMD2_CONCEAL_BIT]; // see RULE19
			explicit_fill_out <= display_command_two_reg[CMD2_FILL_BIT];
			chars_per_row_out <= display_command_two_reg[CMD2_WIDE_BIT] ? CHARS_WIDE : CHARS_NARROW;
			start_line_out <= vertical_display_start_reg; // see RULE20
			// Word address of the page chapter (see RULE21)
			page_base_out <= {page_chapter_pointer_reg[5:0] & CHAPTER_MASK, 10'h000};
			table_a_base_out <= chapter_base(download_chapter_a_pointer_reg); // see RULE22
			table_b_base_out <= chapter_base(download_chapter_b_pointer_reg);
		end
	end

	// Forced defaults give white over transparent with no invert (see RULE18)
	layer_select u_layer_select (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.dot_active_in(dot_active_in),
		.invert_in(invert_attr_in && !display_command_two_reg[CMD2_DEFATTR_BIT]),
		.fg_code_in(display_command_two_reg[CMD2_DEFATTR_BIT] ? WHITE_CODE : fg_code_in),
		.bg_code_in(display_command_two_reg[CMD2_DEFATTR_BIT] ? TRANSPARENT_CODE : bg_code_in),
		.line_code_in(line_code_in),
		.colour_out(dot_colour_out),
		.video_through_out(video_through_out)
	);

	a_rom_locked: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RULE14
		!warn_written_reg |=> !rom_grant_out)
		else $error("font ROM granted before warning time written");
	a_palette_gate: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RULE12
		(palette_req_in && !blanking_in && !test_config_reg[2]) |=> !palette_xfer_ok_out)
		else $error("palette transfer outside blanking");
	a_warn_length: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RULE13
		(bus_state_reg == BUS_IDLE && takeover_req_in && bus_request_warning_time_reg == 8'h02)
		|-> ##50 (bus_state_reg == BUS_WARN) ##1 (bus_state_reg == BUS_OWN))
		else $error("bus request warning length wrong");
	a_rows_follow: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RULE8
		##1 cell_rows_out == ($past(sync_config_reg[3]) ? 4'd12 : 4'd10))
		else $error("cell height does not follow sync bit 3");
	a_chapter_step: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RULE17
		(display_command_two_reg[4] && hsync_in && !hsync_d_reg && !host_wr_in)
		|=> download_chapter_a_pointer_reg == $past(download_chapter_a_pointer_reg) + 8'h01)
		else $error("chapter A pointer did not step");
	a_conceal_inv: assert property (@(posedge ref_clk_in) disable iff (rst_in) // see RULE19
		!$past(rst_in) |-> conceal_en_out == !$past(display_command_two_reg[2]))
		else $error("conceal enable polarity wrong");
endmodule

/* core/tt_regs_pkg.sv */
// Register map, field positions, reset values and timing constants of the display control bank
package tt_regs_pkg;
	localparam logic [19:0] BASE_ADDR = 20'hdc000;
	localparam logic [19:0] COPY_BASE_ADDR = 20'hd1000;
	localparam logic [5:0] LAST_REG_INDEX = 6'h3a;
	localparam logic [5:0] COPY_LAST_INDEX = 6'h3f;
	localparam logic [5:0] IDX_SYNC = 6'h00;
	localparam logic [5:0] IDX_TEST = 6'h01;
	localparam logic [5:0] IDX_WARN = 6'h02;
	localparam logic [5:0] IDX_CMD1 = 6'h03;
	localparam logic [5:0] IDX_CMD2 = 6'h04;
	localparam logic [5:0] IDX_VSTART = 6'h05;
	localparam logic [5:0] IDX_PAGE = 6'h06;
	localparam logic [5:0] IDX_CHAP_A = 6'h07;
	localparam logic [5:0] IDX_CHAP_B = 6'h08;
	localparam logic [7:0] RST_SYNC = 8'hf4;
	localparam logic [7:0] RST_TEST = 8'h04;
	localparam logic [7:0] RST_WARN = 8'h16;
	localparam logic [7:0] RST_CMD1 = 8'h62;
	localparam logic [7:0] RST_CMD2 = 8'h00;
	localparam logic [7:0] RST_VSTART = 8'h1b;
	localparam logic [7:0] RST_PAGE = 8'h00;
	localparam logic [7:0] RST_CHAP_A = 8'h01;
	localparam logic [7:0] RST_CHAP_B = 8'h02;
	// Sync and test register fields
	localparam int SYNC_EXT_BIT = 7;
	localparam int SYNC_SQ_BIT = 6;
	localparam int SYNC_BROAD_BIT = 5;
	localparam int SYNC_MASTER_BIT = 4;
	localparam int SYNC_ROWS_BIT = 3;
	localparam int SYNC_PLL_BIT = 2;
	localparam int SYNC_FSRC_BIT = 1;
	localparam int SYNC_ILACE_BIT = 0;
	localparam int TEST_ANYTIME_BIT = 2;
	// Display command fields
	localparam int CMD1_VIDEO_BIT = 7;
	localparam int CMD1_TEXT_BIT = 6;
	localparam int CMD1_WINDOW_BIT = 5;
	localparam int CMD1_PAL_BIT = 1;
	localparam int CMD1_FLASH_BIT = 0;
	localparam int CMD2_AINC_BIT = 4;
	localparam int CMD2_DEFATTR_BIT = 3;
	localparam int CMD2_CONCEAL_BIT = 2;
	localparam int CMD2_FILL_BIT = 1;
	localparam int CMD2_WIDE_BIT = 0;
	localparam logic [3:0] ROWS_SHORT = 4'd10;
	localparam logic [3:0] ROWS_TALL = 4'd12;
	localparam logic [8:0] EVEN_FIELD_LINES = 9'd312;
	localparam logic [6:0] CHARS_NARROW = 7'd40;
	localparam logic [6:0] CHARS_WIDE = 7'd80;
	localparam logic [4:0] TRANSPARENT_CODE = 5'h00;
	localparam logic [4:0] WHITE_CODE = 5'h0f;
	localparam logic [4:0] WARN_MAX_US = 5'd23;
	localparam int CLK_MHZ = 25;
	localparam logic [4:0] US_CYCLES = 5'(CLK_MHZ);
	localparam int SQ_MHZ = 1;
	// Half period of the square wave, rounded down
	localparam logic [4:0] SQ_HALF_CYCLES = 5'(CLK_MHZ / (2 * SQ_MHZ));
	localparam int CHAPTER_SHIFT = 10;
	localparam logic [5:0] CHAPTER_MASK = 6'h3f;
endpackage

/* dv/host_model.sv */
// Behavioural host processor issuing single-byte memory cycles to the bank
`timescale 1ns/1ps
module host_model import tt_regs_pkg::*; (
	// Clock
	input wire logic ref_clk_in,
	// Bus towards the bank
	output logic [19:0] host_addr_out,
	output logic host_wr_out,
	output logic host_rd_out,
	output logic [7:0] host_wdata_out,
	input wire logic [7:0] host_rdata_in,
	input wire logic host_hit_in
);
	initial begin
		host_addr_out = 20'h00000;
		host_wr_out = 1'b0;
		host_rd_out = 1'b0;
		host_wdata_out = 8'h00;
	end
	// Software aims at the primary registers; copies are touched only on purpose
	task automatic wr_reg(input logic [19:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		host_addr_out <= a;
		host_wdata_out <= d;
		host_wr_out <= 1'b1;
		@(posedge ref_clk_in);
		host_wr_out <= 1'b0;
		// Released lines show the inverse so a stale value cannot pass
		host_addr_out <= ~a;
		host_wdata_out <= ~d;
	endtask
	task automatic wr_warn(input logic [4:0] us);
		wr_reg(BASE_ADDR | 20'(IDX_WARN), {3'h0, (us > WARN_MAX_US) ? WARN_MAX_US : us});
	endtask
	task automatic rd_reg(input logic [19:0] a, output logic [7:0] d, output logic h);
		@(posedge ref_clk_in);
		host_addr_out <= a;
		host_rd_out <= 1'b1;
		@(posedge ref_clk_in);
		host_rd_out <= 1'b0;
		host_addr_out <= ~a;
		#1;
		d = host_rdata_in;
		h = host_hit_in;
	endtask
endmodule

/* dv/tb_top.sv */
// Self-checking bench of the display control register bank
`timescale 1ns/1ps
module tb_top import tt_regs_pkg::*; ;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [19:0] addr;
	logic wr, rd, hit, hsync = 1'b0, blank = 1'b0, take_req = 1'b0, broad = 1'b0;
	logic [7:0] wdata, rdata, start_line;
	logic rom_req = 1'b0, pal_req = 1'b0, act = 1'b0, inv = 1'b0;
	logic [4:0] fg = 5'h00, bg = 5'h00, line = 5'h00, colour;
	logic thru, ext_sync, sq, broad_n, master, pll, fsrc, ilace, pal_ok, bus_req, take;
	logic grant, video_en, text_en, win_en, pal_hi, flash_en, def_attr, conceal_en, fill;
	logic [3:0] rows;
	logic [8:0] field_lines;
	logic [6:0] chars;
	logic [15:0] page_base;
	logic [16:0] tab_a, tab_b;
	int fails = 0, checks_done = 0, cycles = 0;

	always #20 ref_clk_in = ~ref_clk_in;

	host_model host_model_i (.ref_clk_in(ref_clk_in), .host_addr_out(addr), .host_wr_out(wr),
		.host_rd_out(rd), .host_wdata_out(wdata), .host_rdata_in(rdata), .host_hit_in(hit));

	teletext_display_ctrl_regs teletext_display_ctrl_regs_i (.ref_clk_in(ref_clk_in),
		.rst_in(rst_in), .host_addr_in(addr), .host_wr_in(wr), .host_rd_in(rd),
		.host_wdata_in(wdata), .host_rdata_out(rdata), .host_hit_out(hit), .hsync_in(hsync),
		.blanking_in(blank), .takeover_req_in(take_req), .broad_pulse_in(broad),
		.rom_req_in(rom_req), .palette_req_in(pal_req), .dot_active_in(act),
		.invert_attr_in(inv), .fg_code_in(fg), .bg_code_in(bg), .line_code_in(line),
		.dot_colour_out(colour), .video_through_out(thru), .ext_sync_out(ext_sync),
		.square_wave_out(sq), .broad_pulse_n_out(broad_n), .master_out(master),
		.cell_rows_out(rows), .phase_lock_en_out(pll), .field_src_video_out(fsrc),
		.interlace_out(ilace), .field_lines_out(field_lines), .palette_xfer_ok_out(pal_ok),
		.bus_request_out(bus_req), .bus_takeover_out(take), .rom_grant_out(grant),
		.video_en_out(video_en), .text_en_out(text_en), .window_en_out(win_en),
		.palette_high_out(pal_hi), .flash_en_out(flash_en), .default_attr_out(def_attr),
		.conceal_en_out(conceal_en), .explicit_fill_out(fill), .chars_per_row_out(chars),
		.start_line_out(start_line), .page_base_out(page_base), .table_a_base_out(tab_a),
		.table_b_base_out(tab_b));

	task automatic summarize();
		if (fails == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			$display("mismatch at %0t: run did not finish", $time);
			summarize();
		end
	end
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cb(input logic got, input logic exp);
		chk({16'h0, got}, {16'h0, exp});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	function automatic logic [19:0] reg_a(input logic [5:0] i);
		return BASE_ADDR | {14'h0, i};
	endfunction
	task automatic wreg(input logic [5:0] i, input logic [7:0] d);
		host_model_i.wr_reg(reg_a(i), d);
	endtask
	task automatic rchk(input logic [19:0] a, input logic [7:0] e, input logic eh);
		logic [7:0] d;
		logic h;
		host_model_i.rd_reg(a, d, h);
		chk({9'h0, d}, {9'h0, e});
		cb(h, eh);
	endtask

	task automatic t_reset();
		logic [7:0] e [9] = '{RST_SYNC, RST_TEST, RST_WARN, RST_CMD1, RST_CMD2, RST_VSTART,
			RST_PAGE, RST_CHAP_A, RST_CHAP_B};
		for (int i = 0; i < 9; i++) begin
			rchk(reg_a(6'(i)), e[i], 1'b1);
		end
		rchk(reg_a(LAST_REG_INDEX) + 20'h1, 8'h00, 1'b0);
	endtask
	task automatic t_rom();
		@(posedge ref_clk_in);
		rom_req <= 1'b1;
		tick(3);
		cb(grant, 1'b0);
		host_model_i.wr_warn(5'd2);
		tick(3);
		cb(grant, 1'b1);
	endtask
	task automatic t_take();
		int n = 0;
		@(posedge ref_clk_in);
		take_req <= 1'b1;
		tick(3);
		cb(bus_req, 1'b1);
		tick(42);
		cb(take, 1'b0);
		while (take !== 1'b1 && n < 30) begin
			tick(1);
			n++;
		end
		cb(n >= 6 && n <= 8, 1'b1);
		@(posedge ref_clk_in);
		take_req <= 1'b0;
		tick(3);
		cb(bus_req, 1'b0);
	endtask
	task automatic t_sync();
		logic [7:0] v [2] = '{8'h0b, 8'hf4};
		int n = 0;
		logic last;
		@(posedge ref_clk_in);
		broad <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			wreg(IDX_SYNC, v[k]);
			tick(2);
			cb(ext_sync, v[k][7]);
			cb(master, v[k][4]);
			cb(broad_n, !v[k][5]);
			chk(17'(rows), v[k][3] ? 17'(ROWS_TALL) : 17'(ROWS_SHORT));
			cb(pll, v[k][2]);
			cb(fsrc, v[k][1]);
			cb(ilace, v[k][0]);
			chk(17'(field_lines), 17'(EVEN_FIELD_LINES));
		end
		last = sq;
		repeat (48) begin
			tick(1);
			n += int'(sq !== last);
			last = sq;
		end
		chk(17'(n), 17'h4);
	endtask
	task automatic t_pal();
		@(posedge ref_clk_in);
		pal_req <= 1'b1;
		tick(2);
		cb(pal_ok, 1'b1);
		wreg(IDX_TEST, 8'h00);
		tick(2);
		cb(pal_ok, 1'b0);
		@(posedge ref_clk_in);
		blank <= 1'b1;
		tick(2);
		cb(pal_ok, 1'b1);
	endtask
	task automatic t_cmd();
		logic [7:0] c1 [2] = '{8'ha1, 8'h42};
		logic [7:0] c2 [2] = '{8'h0b, 8'h04};
		for (int k = 0; k < 2; k++) begin
			wreg(IDX_CMD1, c1[k]);
			wreg(IDX_CMD2, c2[k]);
			tick(2);
			cb(video_en, c1[k][7]);
			cb(text_en, c1[k][6]);
			cb(win_en, c1[k][5]);
			cb(pal_hi, c1[k][1]);
			cb(flash_en, c1[k][0]);
			cb(def_attr, c2[k][3]);
			cb(conceal_en, !c2[k][2]);
			cb(fill, c2[k][1]);
			chk(17'(chars), c2[k][0] ? 17'(CHARS_WIDE) : 17'(CHARS_NARROW));
		end
	endtask
	task automatic t_ptr();
		wreg(IDX_VSTART, 8'h2c);
		wreg(IDX_PAGE, 8'h3f);
		wreg(IDX_CHAP_A, 8'h05);
		wreg(IDX_CHAP_B, 8'h3f);
		tick(2);
		chk(17'(start_line), 17'h2c);
		chk(17'(page_base), 17'hfc00);
		chk(tab_a, 17'h1400);
		chk(tab_b, 17'hfc00);
		host_model_i.wr_reg(COPY_BASE_ADDR | 20'h3, 8'hff);
		tick(2);
		cb(video_en, 1'b0);
		rchk(COPY_BASE_ADDR | 20'h3, 8'hff, 1'b1);
		rchk(reg_a(IDX_CMD1), 8'h42, 1'b1);
	endtask
	task automatic t_step();
		for (int k = 0; k < 2; k++) begin
			wreg(IDX_CMD2, k == 0 ? 8'h10 : 8'h00);
			@(posedge ref_clk_in);
			hsync <= 1'b1;
			tick(3);
			chk(tab_a, 17'h1800);
			@(posedge ref_clk_in);
			hsync <= 1'b0;
		end
	endtask
	task automatic t_dot();
		logic [4:0] e;
		for (int i = 0; i < 16; i++) begin
			@(posedge ref_clk_in);
			line <= 5'h06;
			act <= i[3];
			inv <= i[2];
			fg <= i[1] ? TRANSPARENT_CODE : 5'h03;
			bg <= i[0] ? TRANSPARENT_CODE : 5'h05;
			e = (i[3] ^ i[2]) ? (i[1] ? 5'h06 : 5'h03) : (i[0] ? 5'h06 : 5'h05);
			tick(1);
			chk(17'(colour), 17'(e));
		end
		@(posedge ref_clk_in);
		line <= TRANSPARENT_CODE;
		tick(1);
		cb(thru, 1'b1);
		wreg(IDX_CMD2, 8'h08);
		@(posedge ref_clk_in);
		line <= 5'h06;
		tick(2);
		chk(17'(colour), 17'(WHITE_CODE));
		@(posedge ref_clk_in);
		act <= 1'b0;
		tick(1);
		chk(17'(colour), 17'h06);
	endtask

	initial begin
		repeat (3) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		t_reset();
		t_rom();
		t_take();
		t_sync();
		t_pal();
		t_cmd();
		t_ptr();
		t_step();
		t_dot();
		summarize();
	end
endmodule
